// ---- rtl/ccpr_cfg.svh ----
// Purpose: constants for the core clock ratio control block
// Assumes: aclk is the reference clock input, 25 MHz
// Notes:   offsets are byte addresses on the AXI4-Lite slave
`ifndef CCPR_CFG_SVH
`define CCPR_CFG_SVH
`define CCPR_OFS_POWER_MGMT_CONTROL_REGISTER      4'h0
`define CCPR_OFS_STATUS     4'h4
`define CCPR_MULT_LSB       0
`define CCPR_MULT_MSB       6
`define CCPR_DSEL_LSB       7
`define CCPR_DSEL_MSB       8
`define CCPR_HALVE_BIT      9
`define CCPR_SDR_LSB        10
`define CCPR_SDR_MSB        12
`define CCPR_DSEL_RST       2'h0
`define CCPR_SDR_RST        3'h2
`define CCPR_ACLK_PERIOD_NS 40
`define CCPR_REL_INPUT_CYC  4096
`define CCPR_REL_CORE_CYC   2
`define CCPR_RESP_OKAY      2'h0
`define CCPR_RESP_SLVERR    2'h2
`endif

// ---- rtl/ccpr_div.sv ----
// Purpose: divides core clock ticks by the sdram clock ratio
// Assumes: core_tick is a one-cycle enable per core clock period
// Notes:   a ratio of zero is treated as one
`timescale 1ns/10ps
module ccpr_div
    import ccpr_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       hold,
    input  wire logic       core_tick,
    input  wire logic [2:0] ratio,
    output logic            sdram_tick
);
    ccpr_div_state_t s;
    ccpr_div_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (hold) begin
            next_s.cnt = 3'h0;
        end else if (core_tick) begin
            // one sdram period per ratio core periods
            if (s.cnt == 3'h0) begin
                next_s.tick = 1'b1;
                next_s.cnt = (ratio == 3'h0) ? 3'h0 : ratio - 3'h1;
            end else begin
                next_s.cnt = s.cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        s <= next_s;
    end

    assign sdram_tick = s.tick;
endmodule

// ---- rtl/ccpr_pkg.sv ----
// Purpose: types for the core clock ratio control block
// Assumes: nothing
// Notes:   field widths match the cfg header positions
package ccpr_pkg;
    typedef struct packed {
        logic [2:0] sdram_clock_ratio;
        logic       input_halving_enable;
        logic [1:0] core_post_divider;
        logic [6:0] loop_multiplier;
    } ccpr_pm_t;

    typedef struct packed {
        ccpr_pm_t    pm;
        logic [12:0] rel_cnt;
        logic [1:0]  core_cnt;
        logic        core_reset;
        logic        peripheral_clock;
        logic        periph_tick;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  waddr;
        logic [31:0] wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ccpr_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } ccpr_div_state_t;
endpackage

// ---- rtl/ccpr_top.sv ----
// Purpose: core clock ratio control and core reset release sequencing
// Assumes: aclk is the reference clock; core_tick marks each core clock period
// Notes:   the analog loop itself is outside; this block sets and reports its ratios
// Function
// - while reset pin is low, ratio comes from strap pins the board drives
// - loop oscillator factor is two times the multiplier times the loop input
// - multiplier from control register, strap-derived during reset
// - core clock is oscillator divided by 2, 4, 8 or 16; default 2 in reset
// - input halving enable halves the reference into the loop
// - peripheral clock runs at half the core clock rate
// - sdram clock period is core period times sdram clock ratio
// - core reset released 4096 input periods plus two core periods after pin release
// - a missed setup window may add one input cycle to the release delay
`timescale 1ns/10ps
`include "ccpr_cfg.svh"
module ccpr_top
    import ccpr_pkg::*;
#(
    parameter int          REL_INPUT_CYC = `CCPR_REL_INPUT_CYC,
    parameter logic [6:0]  STRAP_MULT0   = 7'h08,
    parameter logic [6:0]  STRAP_MULT1   = 7'h10,
    parameter logic [6:0]  STRAP_MULT2   = 7'h20,
    parameter logic [6:0]  STRAP_MULT3   = 7'h10
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        reset_pin_n,
    input  wire logic [1:0]  ratio_strap_pins,
    input  wire logic        core_tick,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic [7:0]       vco_factor,
    output logic             input_halving_enable,
    output logic [4:0]       core_post_divider,
    output logic             core_reset_n,
    output logic             peripheral_clock,
    output logic             periph_tick,
    output logic             sdram_tick
);
    localparam logic [12:0] REL_LAST = 13'(REL_INPUT_CYC - 1);

    ccpr_state_t s;
    ccpr_state_t next_s;
    ccpr_pm_t    wpm;
    logic [6:0]  strap_mult;
    logic [31:0] pm_word;
    logic [31:0] status_word;
    logic        aw_ok;
    logic        w_ok;
    logic [31:0] rd_word;
    logic        rd_err;
    logic        wr_pm;

    // hardware derivation of the multiplier from the strap pins
    always_comb begin
        unique case (ratio_strap_pins)
            2'h0: strap_mult = STRAP_MULT0;
            2'h1: strap_mult = STRAP_MULT1;
            2'h2: strap_mult = STRAP_MULT2;
            2'h3: strap_mult = STRAP_MULT3;
        endcase
    end

    assign pm_word     = {19'h0, s.pm};
    assign aw_ok       = s_axi_awvalid && !s.aw_got && !s.bvalid;
    assign w_ok        = s_axi_wvalid && !s.w_got && !s.bvalid;
    assign wr_pm       = (s.waddr[3:2] == 2'(`CCPR_OFS_POWER_MGMT_CONTROL_REGISTER >> 2));

    // status: core reset flag, strap-derived multiplier, strap pins
    always_comb begin
        status_word = 32'h0;
        status_word[0] = s.core_reset;
        status_word[7:1] = strap_mult;
        status_word[9:8] = ratio_strap_pins;
    end

    // read mux, unmapped offsets answer with an error
    always_comb begin
        rd_word = 32'h0;
        rd_err = 1'b0;
        case (s_axi_araddr[3:2])
            2'(`CCPR_OFS_POWER_MGMT_CONTROL_REGISTER >> 2): begin
                rd_word = pm_word;
            end
            2'(`CCPR_OFS_STATUS >> 2): begin
                rd_word = status_word;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        wpm = ccpr_pm_t'(s.wdata[12:0]);
        next_s.periph_tick = 1'b0;
        // write channel: address and data in either order
        if (aw_ok) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = s_axi_awaddr;
        end
        if (w_ok) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            if (!s_axi_wstrb[0]) begin
                next_s.wdata[7:0] = pm_word[7:0];
            end
            if (!s_axi_wstrb[1]) begin
                next_s.wdata[15:8] = pm_word[15:8];
            end
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.bvalid = 1'b1;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            if (wr_pm) begin
                next_s.bresp = `CCPR_RESP_OKAY;
                if (reset_pin_n) begin
                    next_s.pm = wpm;
                end
            end else begin
                next_s.bresp = `CCPR_RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // read channel
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = rd_err ? `CCPR_RESP_SLVERR : `CCPR_RESP_OKAY;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (!reset_pin_n) begin
            // strap ratio taken while the pin is low
            next_s.pm.loop_multiplier = strap_mult;
            next_s.pm.core_post_divider = `CCPR_DSEL_RST;
            next_s.pm.input_halving_enable = 1'b0;
            next_s.pm.sdram_clock_ratio = `CCPR_SDR_RST;
            next_s.rel_cnt = 13'h0;
            next_s.core_cnt = 2'h0;
            next_s.core_reset = 1'b1;
        end else if (s.core_reset) begin
            // input periods first, then core periods
            // pin sampled on aclk, a late release adds one input cycle
            if (s.rel_cnt != REL_LAST + 13'h1) begin
                next_s.rel_cnt = s.rel_cnt + 13'h1;
            end else if (core_tick) begin
                next_s.core_cnt = s.core_cnt + 2'h1;
                if (s.core_cnt == 2'(`CCPR_REL_CORE_CYC - 1)) begin
                    next_s.core_reset = 1'b0;
                end
            end
        end
        // half-rate peripheral clock, fixed phase in core reset
        if (s.core_reset) begin
            next_s.peripheral_clock = 1'b0;
        end else if (core_tick) begin
            next_s.peripheral_clock = !s.peripheral_clock;
            next_s.periph_tick = !s.peripheral_clock;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.core_reset <= 1'b1;
            s.pm.core_post_divider <= `CCPR_DSEL_RST;
            s.pm.sdram_clock_ratio <= `CCPR_SDR_RST;
            s.pm.loop_multiplier <= STRAP_MULT0;
        end else begin
            s <= next_s;
        end
    end

    ccpr_div u_sdram_div (
        .aclk       (aclk),
        .hold       (s.core_reset),
        .core_tick  (core_tick),
        .ratio      (s.pm.sdram_clock_ratio),
        .sdram_tick (sdram_tick)
    );

    // oscillator factor relative to the loop input
    assign vco_factor = {s.pm.loop_multiplier, 1'b0};
    // loop input is the reference or half of it
    assign input_halving_enable = s.pm.input_halving_enable;
    // post divider 2 << select gives 2, 4, 8, 16
    assign core_post_divider = 5'h02 << s.pm.core_post_divider;
    assign core_reset_n = !s.core_reset;
    assign peripheral_clock = s.peripheral_clock;
    assign periph_tick = s.periph_tick;
    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready = !s.w_got && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
endmodule

// ---- test/ccpr_board.sv ----
// Purpose: board model: reset pin, strap pins, core tick
// Assumes: a tick every PER cycles stands in for the loop
// Notes:   pin stays low 250 cycles after the last strap change
`timescale 1ns/10ps
module ccpr_board
    import ccpr_pkg::*;
#(parameter int PER = 4)(
    input  wire logic       aclk,
    input  wire logic       hold_rst,
    input  wire logic [1:0] strap_sel,
    output logic            reset_pin_n,
    output logic [1:0]      ratio_strap_pins,
    output logic            core_tick
);
    int tcnt = 0;
    int lcnt = 0;
    initial {reset_pin_n, ratio_strap_pins, core_tick} = 4'h0;
    always @(posedge aclk) begin
        tcnt <= (tcnt == PER - 1) ? 0 : tcnt + 1;
        core_tick <= (tcnt == PER - 1);
        if (!reset_pin_n) ratio_strap_pins <= strap_sel;
        lcnt <= (reset_pin_n || strap_sel != ratio_strap_pins) ? 0 : lcnt + 1;
        reset_pin_n <= !hold_rst && (reset_pin_n || lcnt >= 250);
    end
endmodule

// ---- test/ccpr_top_checker.sv ----
// Purpose: port assertions for the clock ratio control block
// Assumes: aclk is the only clock
// Notes:   bound to ccpr_top
`timescale 1ns/10ps
module ccpr_top_checker
    import ccpr_pkg::*;
#(parameter int REL_INPUT_CYC = 4096)(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       reset_pin_n,
    input wire logic       core_tick,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] vco_factor,
    input wire logic       input_halving_enable,
    input wire logic [4:0] core_post_divider,
    input wire logic       core_reset_n,
    input wire logic       peripheral_clock,
    input wire logic       periph_tick,
    input wire logic       sdram_tick
);
    int hi_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk)
        hi_cnt <= (!aresetn || !reset_pin_n) ? 0 : hi_cnt + 1;
    AST_PDIV: assert property ($onehot(core_post_divider) && !core_post_divider[0])
        else $error("post divider not 2 4 8 16");
    AST_VCO: assert property (vco_factor[0] == 1'h0)
        else $error("odd oscillator factor");
    AST_RDEF: assert property (!reset_pin_n && !$past(reset_pin_n) |-> core_post_divider == 5'h02)
        else $error("divider not 2 in reset");
    AST_CHOLD: assert property (!reset_pin_n |=> !core_reset_n)
        else $error("core out of reset with pin low");
    AST_CREL: assert property ($rose(core_reset_n) |-> hi_cnt > REL_INPUT_CYC)
        else $error("core reset released early");
    AST_PTGL: assert property ($changed(peripheral_clock) && core_reset_n && $past(core_reset_n)
                               |-> $past(core_tick))
        else $error("peripheral clock moved without tick");
    AST_PTICK: assert property ($rose(peripheral_clock) |-> ##[0:1] periph_tick)
        else $error("no peripheral tick");
    AST_SDR: assert property (sdram_tick |-> $past(core_tick) || $past(core_tick, 2))
        else $error("sdram tick without core tick");
    AST_QUIET: assert property (!core_reset_n && !$past(core_reset_n, 2) |-> !sdram_tick && !periph_tick)
        else $error("ticks in core reset");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule
bind ccpr_top ccpr_top_checker #(.REL_INPUT_CYC(REL_INPUT_CYC)) chk_u (.aclk, .aresetn, .reset_pin_n,
    .core_tick, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .vco_factor, .input_halving_enable,
    .core_post_divider, .core_reset_n, .peripheral_clock, .periph_tick, .sdram_tick);

// ---- test/ccpr_top_test.sv ----
// Purpose: bus-driven test of the clock ratio control block
// Assumes: short release count, tick every 4 cycles
// Notes:   expected strap factors follow the default strap table
`timescale 1ns/10ps
module ccpr_top_test
    import ccpr_pkg::*;
;
    localparam int REL = 8;
    localparam int PER = 4;
    logic aclk = 1'h0, aresetn = 1'h0, hold_rst = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [1:0] strap_sel = 2'h0, ratio_strap_pins, s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
    logic reset_pin_n, core_tick, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic input_halving_enable, core_reset_n, peripheral_clock, periph_tick, sdram_tick;
    logic [7:0] vco_factor;
    logic [4:0] core_post_divider;
    logic [7:0] exp_vco [4] = '{8'h10, 8'h20, 8'h40, 8'h20};
    int n_fail = 0, n_tests = 0, n, i;
    ccpr_board #(.PER(PER)) board_u (.aclk, .hold_rst, .strap_sel, .reset_pin_n, .ratio_strap_pins, .core_tick);
    ccpr_top #(.REL_INPUT_CYC(REL)) dut_u (.aclk, .aresetn, .reset_pin_n, .ratio_strap_pins, .core_tick,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .vco_factor, .input_halving_enable,
        .core_post_divider, .core_reset_n, .peripheral_clock, .periph_tick, .sdram_tick);
    initial forever #20 aclk = ~aclk;
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        n_fail++;
        summarize();
    endtask
    task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] wv, output logic [31:0] q,
                       output logic [1:0] e);
        logic ta, tr, tw, done;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wv};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        repeat (50) begin
            @(negedge aclk);
            {ta, tr, tw, done} = {s_axi_awready, s_axi_arready, s_axi_wready, w ? s_axi_bvalid : s_axi_rvalid};
            {q, e} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tr) s_axi_arvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (done) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                return;
            end
        end
        tmo();
    endtask
    task automatic gap(input bit s, output int g);
        @(negedge aclk);
        for (g = 0; g < 99 && !(s ? sdram_tick : periph_tick); g++) @(negedge aclk);
        if (g >= 99) tmo();
        for (g = 1; g < 99; g++) begin
            @(negedge aclk);
            if (s ? sdram_tick : periph_tick) break;
        end
        if (g >= 99) tmo();
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 4; i++) begin
            @(posedge aclk);
            strap_sel <= 2'(i);
            hold_rst <= 1'h1;
            repeat (30) @(posedge aclk);
            bus(1'h1, 4'h0, 32'h3FF, d, r);
            bus(1'h0, 4'h4, 32'h0, d, r);
            chk(d, {22'h0, 2'(i), exp_vco[i][7:1], 1'h1});
            chk(vco_factor, exp_vco[i]);
            chk(core_post_divider, 32'h2);
            chk(input_halving_enable, 32'h0);
        end
        $display("strap test done");
        hold_rst <= 1'h0;
        for (n = 0; n < 400 && !reset_pin_n; n++) @(negedge aclk);
        if (n >= 400) tmo();
        for (n = 0; n < 99 && !core_reset_n; n++) @(negedge aclk);
        if (n >= 99) tmo();
        chk(32'(n > REL && n < REL + 4 * PER), 32'h1);
        $display("release test done");
        for (i = 0; i < 4; i++) begin
            v = {19'h0, 3'(i + 1), 1'h1, 2'(i), 7'h05};
            bus(1'h1, 4'h0, v, d, r); // mult 5 keeps the loop in range
            chk({30'h0, r}, 32'h0);
            @(negedge aclk);
            chk(core_post_divider, 32'h2 << i);
            chk(vco_factor, 32'h0A);
            chk(input_halving_enable, 32'h1);
            bus(1'h0, 4'h0, 32'h0, d, r);
            chk(d, v);
            gap(1'h1, n);
            gap(1'h1, n);
            chk(n, (i + 1) * PER);
        end
        $display("ratio test done");
        gap(1'h0, n);
        gap(1'h0, n);
        chk(n, 2 * PER);
        chk(peripheral_clock, 32'h1);
        bus(1'h1, 4'h4, 32'h1, d, r);
        chk({30'h0, r}, 32'h2);
        bus(1'h0, 4'h8, 32'h0, d, r);
        chk({d[29:0], r}, 32'h2);
        $display("clock and map test done");
        summarize();
    end
endmodule
